// ==== srs_defs.svh ====
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
`define SRS_DATA_W      8
`define SRS_ADDR_W      7
`define SRS_NIB_W       4
`define SRS_WDOG_W      16
`define SRS_PRE_W       8
`define SRS_WDOG_CLR    16'h0000
`define SRS_PRE_CLR     8'h00
`define SRS_PRE_WRAP    8'hFF
`define SRS_ACC_RST     8'h00
`define SRS_PDN_RST     1'b1
`define SRS_TMO_RST     1'b1
`define SRS_DEST_ACC    1'b0
`define SRS_DEST_REG    1'b1
`define SRS_OPC_NOP     3'h0
`define SRS_OPC_ROT     3'h1
`define SRS_OPC_SUBREG  3'h2
`define SRS_OPC_SUBLIT  3'h3
`define SRS_OPC_SUBBRW  3'h4
`define SRS_OPC_SWAP    3'h5
`define SRS_OPC_SLEEP   3'h6
`endif

// ==== srs_pkg.sv ====
package srs_pkg;
   typedef enum logic [2:0] {
      SRS_NOP      = 3'h0,
      SRS_ROTATE   = 3'h1,
      SRS_SUB_REG  = 3'h2,
      SRS_SUB_LIT  = 3'h3,
      SRS_SUB_BRW  = 3'h4,
      SRS_SWAP     = 3'h5,
      SRS_SLEEP    = 3'h6
   } srs_op_e;
endpackage

// ==== srs_subtractor.sv ====
`timescale 1ns/1ns
`include "srs_defs.svh"
module srs_subtractor (
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   input  wire logic       carry_in,
   output logic      [7:0] diff,
   output logic            carry_out,
   output logic            digit_carry_out
);
   // Carry in high means no borrow: a + ~b + c
   wire logic [4:0] low_sum;
   wire logic [8:0] full_sum;
   assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
   assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
   assign diff            = full_sum[7:0];
   assign carry_out       = full_sum[8];
   assign digit_carry_out = low_sum[4];
endmodule

// ==== srs_exec.sv ====
// Function
// - Rotate right: old carry into bit 7, old bit 0 into carry.
// - Destination bit 0 writes accumulator, 1 writes file register back.
// - Power-down instruction clears power-down flag, sets time-out flag.
// - Power-down instruction clears watchdog counter and its prescaler.
// - Register minus accumulator, two's complement, to selected destination.
// - Carry/digit carry set when subtrahend does not exceed minuend (byte/nibble).
// - Literal minus accumulator into accumulator, updating carry, digit carry, zero.
// - Register minus accumulator minus inverted carry, updates carry, digit carry, zero.
// - Swap nibbles of addressed file register to selected destination.
`timescale 1ns/1ns
`include "srs_defs.svh"
module srs_exec (
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   input  wire logic                     exec_valid,
   input  wire srs_pkg::srs_op_e         exec_op,
   input  wire logic [`SRS_ADDR_W-1:0]   file_addr,
   input  wire logic                     dest_sel,
   input  wire logic [`SRS_DATA_W-1:0]   literal,
   input  wire logic [`SRS_DATA_W-1:0]   file_rdata,
   input  wire logic                     watchdog_tick,
   output logic      [`SRS_ADDR_W-1:0]   file_raddr,
   output logic                          file_we,
   output logic      [`SRS_ADDR_W-1:0]   file_waddr,
   output logic      [`SRS_DATA_W-1:0]   file_wdata,
   output logic      [`SRS_DATA_W-1:0]   acc,
   output logic                          carry_flag,
   output logic                          digit_carry_flag,
   output logic                          zero_flag,
   output logic                          powerdown_flag,
   output logic                          timeout_flag,
   output logic      [`SRS_WDOG_W-1:0]   watchdog_counter,
   output logic      [`SRS_PRE_W-1:0]    watchdog_prescaler
);
   // File read is combinational; the register file answers in the same cycle
   assign file_raddr = file_addr;

   wire logic       is_rot;
   wire logic       is_swap;
   wire logic       is_sreg;
   wire logic       is_slit;
   wire logic       is_sbrw;
   wire logic       is_sleep;
   wire logic       is_sub;
   wire logic       is_fileop;
   assign is_rot    = exec_valid && (exec_op == srs_pkg::SRS_ROTATE);
   assign is_swap   = exec_valid && (exec_op == srs_pkg::SRS_SWAP);
   assign is_sreg   = exec_valid && (exec_op == srs_pkg::SRS_SUB_REG);
   assign is_slit   = exec_valid && (exec_op == srs_pkg::SRS_SUB_LIT);
   assign is_sbrw   = exec_valid && (exec_op == srs_pkg::SRS_SUB_BRW);
   assign is_sleep  = exec_valid && (exec_op == srs_pkg::SRS_SLEEP);
   assign is_sub    = is_sreg || is_slit || is_sbrw;
   assign is_fileop = is_rot || is_swap || is_sreg || is_sbrw;

   wire logic [7:0] sub_minuend;
   wire logic       sub_cin;
   wire logic [7:0] sub_diff;
   wire logic       sub_c;
   wire logic       sub_dc;
   assign sub_minuend = is_slit ? literal : file_rdata;
   // Plain subtracts inject carry 1; borrow form feeds the stored carry
   assign sub_cin     = is_sbrw ? carry_flag : 1'b1;

   srs_subtractor u_sub (
      .minuend         (sub_minuend),
      .subtrahend      (acc),
      .carry_in        (sub_cin),
      .diff            (sub_diff),
      .carry_out       (sub_c),
      .digit_carry_out (sub_dc)
   );

   wire logic [7:0] rot_val;
   wire logic [7:0] swap_val;
   wire logic [7:0] result;
   assign rot_val  = {carry_flag, file_rdata[7:1]};
   assign swap_val = {file_rdata[3:0], file_rdata[7:4]};
   assign result   = is_rot ? rot_val : (is_swap ? swap_val : sub_diff);

   wire logic to_acc;
   wire logic to_reg;
   assign to_acc = is_slit || (is_fileop && (dest_sel == `SRS_DEST_ACC));
   assign to_reg = is_fileop && (dest_sel == `SRS_DEST_REG);

   logic [7:0] acc_r;
   logic       c_r;
   logic       dcy_r;
   logic       z_r;
   logic       pdn_r;
   logic       tmo_r;
   logic [15:0] wdog_r;
   logic [7:0]  pre_r;
   logic        we_r;
   logic [6:0]  waddr_r;
   logic [7:0]  wdata_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         acc_r <= `SRS_ACC_RST;
         c_r   <= 1'b0;
         dcy_r <= 1'b0;
         z_r   <= 1'b0;
      end else begin
         if (to_acc) acc_r <= result;
         if (is_rot) c_r <= file_rdata[0];
         else if (is_sub) c_r <= sub_c;
         if (is_sub) dcy_r <= sub_dc;
         if (is_sub) z_r <= (sub_diff == 8'h00);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         we_r    <= 1'b0;
         waddr_r <= 7'h00;
         wdata_r <= 8'h00;
      end else begin
         we_r <= to_reg;
         if (to_reg) begin
            waddr_r <= file_addr;
            wdata_r <= result;
         end
      end
   end

   // Status flags read as set after reset: no sleep executed yet
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pdn_r <= `SRS_PDN_RST;
         tmo_r <= `SRS_TMO_RST;
      end else if (is_sleep) begin
         pdn_r <= 1'b0;
         tmo_r <= 1'b1;
      end
   end

   // Simple prescaled watchdog; timeout handling lives elsewhere
   always_ff @(posedge core_clk) begin
      if (!resetn || is_sleep) begin
         wdog_r <= `SRS_WDOG_CLR;
         pre_r  <= `SRS_PRE_CLR;
      end else if (watchdog_tick) begin
         pre_r <= pre_r + 8'h01;
         if (pre_r == `SRS_PRE_WRAP) wdog_r <= wdog_r + 16'h0001;
      end
   end

   assign acc                = acc_r;
   assign carry_flag         = c_r;
   assign digit_carry_flag   = dcy_r;
   assign zero_flag          = z_r;
   assign powerdown_flag     = pdn_r;
   assign timeout_flag       = tmo_r;
   assign watchdog_counter   = wdog_r;
   assign watchdog_prescaler = pre_r;
   assign file_we            = we_r;
   assign file_waddr         = waddr_r;
   assign file_wdata         = wdata_r;

   property p_rot_carry;
      @(posedge core_clk) disable iff (!resetn)
      is_rot |=> carry_flag == $past(file_rdata[0]);
   endproperty
   a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

   property p_dest_reg;
      @(posedge core_clk) disable iff (!resetn)
      to_reg |=> file_we && file_waddr == $past(file_addr) && acc == $past(acc);
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("register dest wrong");

   sequence s_sleep;
      is_sleep;
   endsequence
   property p_sleep_flags;
      @(posedge core_clk) disable iff (!resetn)
      s_sleep |=> !powerdown_flag && timeout_flag;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

   property p_sleep_wdog;
      @(posedge core_clk) disable iff (!resetn)
      s_sleep |=> watchdog_counter == 16'h0000 && watchdog_prescaler == 8'h00;
   endproperty
   a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

   property p_subreg_acc;
      @(posedge core_clk) disable iff (!resetn)
      is_sreg && !dest_sel |=> acc == $past(file_rdata) - $past(acc);
   endproperty
   a_subreg_acc: assert property (p_subreg_acc) else $error("subtract result wrong");

   property p_sub_carry;
      @(posedge core_clk) disable iff (!resetn)
      (is_sreg || is_slit) |=> carry_flag == ($past(acc) <= $past(sub_minuend));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

   property p_sub_dc;
      @(posedge core_clk) disable iff (!resetn)
      (is_sreg || is_slit)
         |=> digit_carry_flag == ($past(acc[3:0]) <= $past(sub_minuend[3:0]));
   endproperty
   a_sub_dc: assert property (p_sub_dc) else $error("digit carry wrong");

   property p_sublit;
      @(posedge core_clk) disable iff (!resetn)
      is_slit |=> acc == $past(literal) - $past(acc);
   endproperty
   a_sublit: assert property (p_sublit) else $error("literal subtract wrong");

   property p_subbrw;
      @(posedge core_clk) disable iff (!resetn)
      is_sbrw && !dest_sel
         |=> acc == $past(file_rdata) - $past(acc) - {7'h00, !$past(carry_flag)};
   endproperty
   a_subbrw: assert property (p_subbrw) else $error("borrow subtract wrong");

   property p_swap;
      @(posedge core_clk) disable iff (!resetn)
      is_swap && dest_sel |=> file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])};
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_zero_keep;
      @(posedge core_clk) disable iff (!resetn)
      (is_rot || is_swap) |=> $stable(zero_flag);
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero changed");
endmodule

// ==== test_srs_exec.sv ====
`timescale 1ns/1ns
`include "srs_defs.svh"
module test_srs_exec;
   logic                 core_clk = 1'b0;
   logic                 resetn = 1'b0;
   logic                 exec_valid = 1'b0;
   srs_pkg::srs_op_e     exec_op = srs_pkg::SRS_NOP;
   logic [6:0]           file_addr = 7'h00;
   logic                 dest_sel = 1'b0;
   logic [7:0]           literal = 8'h00;
   logic [7:0]           file_rdata = 8'h00;
   logic                 watchdog_tick = 1'b0;
   wire  [6:0]           file_raddr;
   wire                  file_we;
   wire  [6:0]           file_waddr;
   wire  [7:0]           file_wdata;
   wire  [7:0]           acc;
   wire                  carry_flag;
   wire                  digit_carry_flag;
   wire                  zero_flag;
   wire                  powerdown_flag;
   wire                  timeout_flag;
   wire  [15:0]          watchdog_counter;
   wire  [7:0]           watchdog_prescaler;
   int                   errors = 0;
   int                   comparisons = 0;
   logic [7:0]           ea = 8'h00;
   logic                 ec = 1'b0;
   logic                 edc = 1'b0;
   logic                 ez = 1'b0;
   logic                 epd = 1'b1;
   logic                 eto = 1'b1;

   srs_exec u_srs_exec (
      .core_clk           (core_clk),
      .resetn             (resetn),
      .exec_valid         (exec_valid),
      .exec_op            (exec_op),
      .file_addr          (file_addr),
      .dest_sel           (dest_sel),
      .literal            (literal),
      .file_rdata         (file_rdata),
      .watchdog_tick      (watchdog_tick),
      .file_raddr         (file_raddr),
      .file_we            (file_we),
      .file_waddr         (file_waddr),
      .file_wdata         (file_wdata),
      .acc                (acc),
      .carry_flag         (carry_flag),
      .digit_carry_flag   (digit_carry_flag),
      .zero_flag          (zero_flag),
      .powerdown_flag     (powerdown_flag),
      .timeout_flag       (timeout_flag),
      .watchdog_counter   (watchdog_counter),
      .watchdog_prescaler (watchdog_prescaler)
   );

   always #2 core_clk = ~core_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Model works from the expected state, never from the outputs
   task automatic ex(input srs_pkg::srs_op_e op, input logic [7:0] fr, input logic [6:0] ad,
                     input logic d, input logic [7:0] lit);
      logic [7:0] m;
      logic [7:0] res;
      logic       bw;
      logic [7:0] dif;
      logic       c_n;
      logic       dc_n;
      logic       wr;
      m = (op == srs_pkg::SRS_SUB_LIT) ? lit : fr;
      // Borrow form takes one more away when carry is clear
      bw = (op == srs_pkg::SRS_SUB_BRW) ? !ec : 1'b0;
      dif = m - ea - {7'h00, bw};
      c_n = ({1'b0, ea} + {8'h00, bw}) <= {1'b0, m};
      dc_n = ({1'b0, ea[3:0]} + {4'h0, bw}) <= {1'b0, m[3:0]};
      wr = 1'b0;
      res = ea;
      @(posedge core_clk);
      exec_valid <= 1'b1;
      exec_op <= op;
      file_addr <= ad;
      dest_sel <= d;
      literal <= lit;
      file_rdata <= fr;
      @(posedge core_clk);
      exec_valid <= 1'b0;
      case (op)
         srs_pkg::SRS_ROTATE: begin
            res = {ec, fr[7:1]};
            ec = fr[0];
         end
         srs_pkg::SRS_SUB_REG, srs_pkg::SRS_SUB_LIT, srs_pkg::SRS_SUB_BRW: begin
            res = dif;
            ec = c_n;
            edc = dc_n;
            ez = (res == 8'h00);
         end
         srs_pkg::SRS_SWAP: res = {fr[3:0], fr[7:4]};
         srs_pkg::SRS_SLEEP: begin
            epd = 1'b0;
            eto = 1'b1;
         end
         default: ;
      endcase
      if (op != srs_pkg::SRS_NOP && op != srs_pkg::SRS_SLEEP) begin
         wr = d && (op != srs_pkg::SRS_SUB_LIT);
         if (!wr)
            ea = res;
      end
      #1;
      check({acc, carry_flag, digit_carry_flag, zero_flag, powerdown_flag, timeout_flag,
             file_we, 2'b00}, {ea, ec, edc, ez, epd, eto, wr, 2'b00});
      check({9'h000, file_raddr}, {9'h000, ad});
      if (wr)
         check({1'b0, file_waddr, file_wdata}, {1'b0, ad, res});
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      end_of_test;
   end

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      check({acc, carry_flag, digit_carry_flag, zero_flag, powerdown_flag, timeout_flag,
             file_we, 2'b00}, 16'h0018);
      check(watchdog_counter, 16'h0000);
      check({8'h00, watchdog_prescaler}, 16'h0000);
      $display("reset test done");
      ex(srs_pkg::SRS_SUB_LIT, 8'h00, 7'h00, 1'b1, 8'h00);
      ex(srs_pkg::SRS_SUB_LIT, 8'h00, 7'h00, 1'b0, 8'h3A);
      ex(srs_pkg::SRS_SUB_REG, 8'h39, 7'h7F, 1'b1, 8'h00);
      ex(srs_pkg::SRS_SUB_REG, 8'h3A, 7'h01, 1'b0, 8'h00);
      ex(srs_pkg::SRS_SUB_LIT, 8'h00, 7'h00, 1'b0, 8'h18);
      ex(srs_pkg::SRS_SUB_BRW, 8'h20, 7'h02, 1'b0, 8'h00);
      ex(srs_pkg::SRS_SUB_LIT, 8'h00, 7'h00, 1'b0, 8'h07);
      ex(srs_pkg::SRS_SUB_BRW, 8'h00, 7'h00, 1'b1, 8'h00);
      $display("subtract test done");
      ex(srs_pkg::SRS_ROTATE, 8'h81, 7'h55, 1'b1, 8'h00);
      ex(srs_pkg::SRS_ROTATE, 8'h02, 7'h2A, 1'b0, 8'h00);
      ex(srs_pkg::SRS_SWAP, 8'hA5, 7'h7F, 1'b1, 8'h00);
      ex(srs_pkg::SRS_SWAP, 8'h3C, 7'h00, 1'b0, 8'h00);
      ex(srs_pkg::SRS_NOP, 8'hFF, 7'h10, 1'b1, 8'hFF);
      $display("rotate and swap test done");
      // Prescaler wraps twice in 600 ticks and stops at 88
      @(posedge core_clk);
      watchdog_tick <= 1'b1;
      repeat (600) @(posedge core_clk);
      watchdog_tick <= 1'b0;
      #1;
      check(watchdog_counter, 16'h0002);
      check({8'h00, watchdog_prescaler}, 16'h0058);
      ex(srs_pkg::SRS_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
      check(watchdog_counter, 16'h0000);
      check({8'h00, watchdog_prescaler}, 16'h0000);
      $display("sleep test done");
      end_of_test;
   end
endmodule
